/* logic/rci_status_ind.sv */
// Recloser status indication stage with Wishbone registers and interrupt
`timescale 1ns/100ps
module rci_status_ind (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Request and enable pins
    input  wire logic              reclose_request_1_i,
    input  wire logic              reclose_request_2_i,
    input  wire logic              reclose_request_3_i,
    input  wire logic              reclose_request_4_i,
    input  wire logic              reclose_request_5_i,
    input  wire logic              recloser_enable_input_i,
    // Sequencer state
    input  wire rci_pkg::rci_seq_t seq_i,
    // Indications and interrupt
    output rci_pkg::rci_ind_t      ind_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Fixed priority: bit 0 (request 1) wins over all others
    function automatic logic [4:0] prio_pick(input logic [4:0] req);
        logic [4:0] r;
        r = 5'h00;
        for (int i = rci_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                r = 5'h00;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // Shot numbers 1..5 to one-hot; anything else decodes to none
    function automatic logic [4:0] shot_decode(input logic [2:0] n);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < rci_pkg::NUM_SHOT; i++) begin
            if (n == 3'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [5:0] pins_sync;
    wire  [4:0] req_s = pins_sync[4:0];
    wire        en_s  = pins_sync[5];

    rci_sync #(
        .W (rci_pkg::SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({recloser_enable_input_i, reclose_request_5_i,
                   reclose_request_4_i, reclose_request_3_i,
                   reclose_request_2_i, reclose_request_1_i}),
        .sync_o  (pins_sync)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] ctrl;
    logic [3:0] irq_mask;
    logic [3:0] irq_stat;
    logic       dead_q;

    wire fn_on   = ctrl[rci_pkg::CTRL_FN_ON];
    wire ext_sel = ctrl[rci_pkg::CTRL_EXT_SEL];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire take     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_take  = take & wb_we_i & wb_sel_i[0];
    wire hit_ctrl = wb_adr_i == rci_pkg::REG_CTRL;
    wire hit_ind  = wb_adr_i == rci_pkg::REG_IND;
    wire hit_stat = wb_adr_i == rci_pkg::REG_IRQ_STAT;
    wire hit_mask = wb_adr_i == rci_pkg::REG_IRQ_MASK;
    wire rd_clear = take & ~wb_we_i & hit_stat;

    wire [31:0] rd_data =
        hit_ctrl ? {30'h0, ctrl}              :
        hit_ind  ? {18'h0, ind_o}             :
        hit_stat ? {28'h0, irq_stat}          :
        hit_mask ? {28'h0, irq_mask}          :
                   32'h0;

    // ------------------------------------------------------------
    // Indication decode
    // ------------------------------------------------------------
    rci_pkg::rci_ind_t next_ind;

    // Enabled when the function is on, unless the external input is chosen and inactive
    wire next_en  = fn_on & (~ext_sel | en_s);              // [RULE3] [RULE11]
    wire next_dis = ext_sel & ~en_s;                        // [RULE4] [RULE11]
    wire dead_end = dead_q & ~seq_i.dead_timing;
    wire rel_shot = ~seq_i.running | seq_i.shot_end;        // [RULE12]

    always_comb begin
        next_ind = ind_o;
        next_ind.recloser_enabled_ind  = next_en;
        next_ind.recloser_disabled_ind = next_dis;
        next_ind.sequencer_running_ind = seq_i.running;     // [RULE7]
        // Opening the breaker wins over the end of timing
        if (seq_i.breaker_opened) begin
            next_ind.sequence_active_ind = 1'b1;            // [RULE5]
        end else if (dead_end) begin
            next_ind.sequence_active_ind = 1'b0;            // [RULE5]
        end
        // Served request is caught at shot start, not tracked live
        if (rel_shot) begin
            next_ind.request_served_ind = 5'h00;            // [RULE12]
            next_ind.shot_executing_ind = 5'h00;            // [RULE12]
        end else if (seq_i.shot_start) begin
            next_ind.request_served_ind = prio_pick(req_s); // [RULE6] [RULE10]
            next_ind.shot_executing_ind =
                shot_decode(seq_i.shot_num);                // [RULE8] [RULE9]
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    logic [3:0] events;
    always_comb begin
        events = 4'h0;
        events[rci_pkg::IRQ_SHOT]    = next_ind.shot_executing_ind != 5'h00
                                       && ind_o.shot_executing_ind == 5'h00;
        events[rci_pkg::IRQ_SEQ_ON]  = next_ind.sequence_active_ind
                                       & ~ind_o.sequence_active_ind;
        events[rci_pkg::IRQ_SEQ_OFF] = ~next_ind.sequence_active_ind
                                       & ind_o.sequence_active_ind;
        events[rci_pkg::IRQ_EN_CHG]  = next_en ^ ind_o.recloser_enabled_ind;
    end

    // A set in the clearing cycle survives the read
    wire [3:0] next_stat = (rd_clear ? 4'h0 : irq_stat) | events;

    // Mask written this cycle already counts, so the level never lags a write
    wire [3:0] next_mask = (wr_take && hit_mask) ? wb_dat_i[3:0] : irq_mask;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Indications only; breaker commands stay with object control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_o  <= rci_pkg::IND_RST;
            dead_q <= 1'b0;
        end else begin
            ind_o  <= next_ind;                             // [RULE1]
            dead_q <= seq_i.dead_timing;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= rci_pkg::CTRL_RST;
            irq_mask <= rci_pkg::IRQ_MASK_RST;
            irq_stat <= 4'h0;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= next_stat;
            irq_o    <= |(next_stat & next_mask);
            if (wr_take && hit_ctrl) begin
                ctrl <= wb_dat_i[1:0];
            end
            if (wr_take && hit_mask) begin
                irq_mask <= wb_dat_i[3:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= take;
            if (take) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_enable_on: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        (fn_on && (!ext_sel || en_s)) |=> ind_o.recloser_enabled_ind)
        else $error("enabled indication missing");

    a_disable_cause: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        ind_o.recloser_disabled_ind |-> $past(ext_sel) && !$past(en_s))
        else $error("disabled indication without cause");

    a_ext_unused: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
        (!ext_sel && fn_on) |=> !ind_o.recloser_disabled_ind
                                && ind_o.recloser_enabled_ind)
        else $error("external input acted while not selected");

    a_seq_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        seq_i.breaker_opened |=> ind_o.sequence_active_ind)
        else $error("sequence active not set on opening");

    a_seq_end: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        ($fell(seq_i.dead_timing) && !seq_i.breaker_opened)
        |=> !ind_o.sequence_active_ind)
        else $error("sequence active held after timing ended");

    a_run_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        ind_o.sequencer_running_ind == $past(seq_i.running))
        else $error("running indication does not follow");

    a_req_served: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (seq_i.shot_start && !rel_shot && req_s[2] && req_s[1:0] == 2'h0)
        |=> ind_o.request_served_ind == 5'h04)
        else $error("wrong served request");

    a_req_prio: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        (seq_i.shot_start && !rel_shot && req_s[0])
        |=> ind_o.request_served_ind == 5'h01 [*1] ##1
            ($past(rel_shot) || $past(seq_i.shot_start)
             || ind_o.request_served_ind == 5'h01))
        else $error("request 1 not preferred or not held");

    a_shot_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        (seq_i.shot_start && !rel_shot && seq_i.shot_num == 3'h3)
        |=> ind_o.shot_executing_ind == 5'h04)
        else $error("shot 3 indication wrong");

    a_shot_high: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
        (seq_i.shot_start && !rel_shot && seq_i.shot_num == 3'h5)
        |=> ind_o.shot_executing_ind == 5'h10)
        else $error("shot 5 indication wrong");

    a_one_hot: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
        $onehot0(ind_o.request_served_ind) && $onehot0(ind_o.shot_executing_ind))
        else $error("more than one indication active");

    a_release: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
        rel_shot |=> ind_o.request_served_ind == 5'h00
                     && ind_o.shot_executing_ind == 5'h00)
        else $error("indication not released");

    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        irq_o == |(irq_stat & irq_mask))
        else $error("interrupt does not match status and mask");

    // A read is the only way to drop a status bit, so a late clear shows up here
    a_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        !rd_clear |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit lost without a read");

    a_enable_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        !fn_on |=> !ind_o.recloser_enabled_ind)
        else $error("enabled indication with function off");

    a_disable_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        (!ext_sel || en_s) |=> !ind_o.recloser_disabled_ind)
        else $error("disabled indication while input unused or active");

    // Sequence indication must ride out the whole timing, not only its start
    a_seq_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        (ind_o.sequence_active_ind && !$fell(seq_i.dead_timing))
        |=> ind_o.sequence_active_ind)
        else $error("sequence active dropped while timing");

    a_served_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (ind_o.request_served_ind != 5'h00 && !rel_shot && !seq_i.shot_start)
        |=> $stable(ind_o.request_served_ind))
        else $error("served indication moved during a shot");

    a_shot_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        (ind_o.shot_executing_ind != 5'h00 && !rel_shot && !seq_i.shot_start)
        |=> $stable(ind_o.shot_executing_ind))
        else $error("shot indication moved during a shot");

    a_req_second: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        (seq_i.shot_start && !rel_shot && req_s[1:0] == 2'h2)
        |=> ind_o.request_served_ind == 5'h02)
        else $error("request 2 not picked over lower requests");

    // Out-of-range numbers must not light a shot, or two could appear at once
    a_shot_none: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
        (seq_i.shot_start && !rel_shot
         && (seq_i.shot_num == 3'h0 || seq_i.shot_num > 3'h5))
        |=> ind_o.shot_executing_ind == 5'h00)
        else $error("shot indication for an invalid shot number");

endmodule

/* logic/rci_pkg.sv */
// Package: constants and carriers for the recloser status indications
// Functional notes
// (RULE1) Outputs are indications only, never breaker commands
// (RULE2) Object control alone opens and closes breaker
// (RULE3) Enabled indication follows recloser enabled state
// (RULE4) Disabled only when external select set, input inactive
// (RULE5) Sequence active from breaker opened until timing stops
// (RULE6) Five served indications follow the starting request
// (RULE7) Running indication follows sequencer running mode
// (RULE8) Shot n indication while shot n executes
// (RULE9) Shots 4 and 5 have their own indications
// (RULE10) Request 1 highest priority, request 5 lowest
// (RULE11) Setting chooses whether external enable input counts
// (RULE12) At most one served and shot indication; prompt release
package rci_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_IND      = 8'h04;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h0C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_FN_ON   = 0;
    localparam int          CTRL_EXT_SEL = 1;
    localparam logic [1:0]  CTRL_RST     = 2'h1;
    localparam int          NUM_REQ      = 5;
    localparam int          NUM_SHOT     = 5;
    localparam int          IRQ_W        = 4;
    localparam int          IRQ_SHOT     = 0;
    localparam int          IRQ_SEQ_ON   = 1;
    localparam int          IRQ_SEQ_OFF  = 2;
    localparam int          IRQ_EN_CHG   = 3;
    localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
    localparam int          SYNC_W       = 6;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Sequencer state, same clock as this block
    typedef struct packed {
        logic       running;
        logic       breaker_opened;
        logic       dead_timing;
        logic       shot_start;
        logic       shot_end;
        logic [2:0] shot_num;
    } rci_seq_t;

    // Indication bundle, low bits of the indication register
    typedef struct packed {
        logic [4:0] shot_executing_ind;
        logic [4:0] request_served_ind;
        logic       sequencer_running_ind;
        logic       sequence_active_ind;
        logic       recloser_disabled_ind;
        logic       recloser_enabled_ind;
    } rci_ind_t;

    localparam rci_ind_t IND_RST = '0;

endpackage

/* logic/rci_sync.sv */
// Two flip-flop synchroniser for asynchronous input pins
`timescale 1ns/100ps
module rci_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins and synchronised copy
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

/* verification/rci_seq_model.sv */
// Far-side sequencer and object-control stand-in
`timescale 1ns/100ps
module rci_seq_model (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Commands from the bench
    input  wire logic [4:0]   cmd_i,
    input  wire logic [2:0]   num_i,
    // Sequencer state
    output rci_pkg::rci_seq_t seq_o
);
    // Breaker commands stay on this side; the block only sees state
    // Shot number is junk outside shot_start, so a late sampler is caught
    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_o <= '0;
        end else begin
            seq_o <= {cmd_i, cmd_i[1] ? num_i : ~seq_o.shot_num};
        end
    end
endmodule

/* verification/rci_status_ind_tb_top.sv */
// Self-checking bench for the recloser status indication stage
`timescale 1ns/100ps
module rci_status_ind_tb_top;
    logic              clk_i;
    logic              rst_i;
    logic              cyc, stb, we;
    logic [7:0]        adr;
    logic [31:0]       dat, rdat, q, e;
    logic              ack, irq;
    logic [5:0]        pins, s1, s2;
    logic [4:0]        cmd;
    logic [2:0]        num;
    logic [1:0]        ctrl;
    logic [3:0]        mask, stat;
    logic              dprev, m_irq, mack, tk;
    logic [3:0]        ev, sel, wsel;
    logic [31:0]       seed;
    int                fail_count, checked, i;
    rci_pkg::rci_seq_t seq;
    rci_pkg::rci_ind_t ind, m_ind, n;

    rci_status_ind rci_status_ind_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .reclose_request_1_i(pins[0]),
        .reclose_request_2_i(pins[1]), .reclose_request_3_i(pins[2]),
        .reclose_request_4_i(pins[3]), .reclose_request_5_i(pins[4]),
        .recloser_enable_input_i(pins[5]), .seq_i(seq), .ind_o(ind), .irq_o(irq));
    rci_seq_model rci_seq_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd),
        .num_i(num), .seq_o(seq));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Reference model, mirrors the pin synchroniser depth
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            m_ind = '0; stat = '0; ctrl = 2'h1; mask = '0; mack = 1'b0;
            s1 = '0; s2 = '0; dprev = 1'b0; m_irq = 1'b0;
        end else begin
            n = m_ind;
            n.recloser_enabled_ind = ctrl[0] & (~ctrl[1] | s2[5]);
            n.recloser_disabled_ind = ctrl[1] & ~s2[5];
            n.sequencer_running_ind = seq.running;
            if (seq.breaker_opened) n.sequence_active_ind = 1'b1;
            else if (dprev & ~seq.dead_timing) n.sequence_active_ind = 1'b0;
            if (seq.shot_end | ~seq.running) begin
                n.request_served_ind = '0;
                n.shot_executing_ind = '0;
            end else if (seq.shot_start) begin
                // Lowest set bit wins: request 1 outranks the rest
                n.request_served_ind = s2[4:0] & (~s2[4:0] + 5'h01);
                n.shot_executing_ind = (seq.shot_num inside {[1:5]}) ?
                    5'h01 << (seq.shot_num - 3'h1) : 5'h00;
            end
            ev[0] = (n.shot_executing_ind != 5'h00) && (m_ind.shot_executing_ind == 5'h00);
            ev[1] = n.sequence_active_ind & ~m_ind.sequence_active_ind;
            ev[2] = ~n.sequence_active_ind & m_ind.sequence_active_ind;
            ev[3] = n.recloser_enabled_ind ^ m_ind.recloser_enabled_ind;
            // Bus side of the model: a read clears, a new event survives it
            tk = cyc & stb & ~mack;
            if (tk && !we && adr == 8'h08) stat = '0;
            stat = stat | ev;
            if (tk && we && sel[0] && adr == 8'h00) ctrl = dat[1:0];
            if (tk && we && sel[0] && adr == 8'h0C) mask = dat[3:0];
            mack = tk;
            dprev = seq.dead_timing;
            s2 = s1;
            s1 = pins;
            m_ind = n;
            m_irq = |(stat & mask);
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic summarize;
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask

    // Classic single cycle; waits for ack, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= wsel;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask

    // Settle, then compare indications and interrupt
    task automatic cp;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk({18'h0, ind}, {18'h0, m_ind});
        chk({31'h0, irq}, {31'h0, m_irq});
        @(posedge clk_i);
    endtask

    task automatic pulse(input logic [4:0] m);
        cmd <= cmd | m;
        @(posedge clk_i);
        cmd <= cmd & ~m;
        @(posedge clk_i);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; dat = '0;
        pins = 6'h20; cmd = '0; num = '0; seed = 32'hE; sel = 4'h0; wsel = 4'hF;
        fail_count = 0; checked = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0); chk(q, 32'h1);
        wb(1'b0, 8'h0C, 32'h0); chk(q, 32'h0);
        wb(1'b0, 8'h10, 32'h0); chk(q, 32'h0);
        wb(1'b1, 8'h04, 32'hFFFF);
        repeat (3) @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0);
        cp();
        for (i = 0; i < 8; i++) begin
            pins[5] <= i[2];
            wb(1'b1, 8'h00, {30'h0, i[1:0]});
            cp();
        end
        wsel = 4'hE;
        wb(1'b1, 8'h00, 32'h1);
        wsel = 4'hF;
        wb(1'b0, 8'h00, 32'h0); chk(q, 32'h3);
        wb(1'b1, 8'h00, 32'h1);
        cmd <= 5'h10;
        cp();
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            pins[4:0] <= seed[4:0];
            repeat (3) @(posedge clk_i);
            num <= i[2:0];
            pulse(5'h02);
            cp();
            wb(1'b0, 8'h04, 32'h0); chk(q, {18'h0, m_ind});
            pulse(5'h01);
            cp();
        end
        pins[4:0] <= 5'h14;
        repeat (3) @(posedge clk_i);
        num <= 3'h2;
        pulse(5'h02);
        cp();
        cmd <= 5'h00;
        cp();
        pulse(5'h02);
        cp();
        wb(1'b1, 8'h0C, 32'hF);
        wb(1'b0, 8'h08, 32'h0);
        cmd <= 5'h10;
        @(posedge clk_i);
        pulse(5'h08);
        cp();
        e = {28'h0, stat};
        wb(1'b0, 8'h08, 32'h0); chk(q, e);
        cp();
        cmd <= 5'h14;
        cp();
        wb(1'b1, 8'h0C, 32'h0);
        cmd <= 5'h10;
        cp();
        summarize();
    end
endmodule
